/* bench/ppr_periph_model.sv */
// far-side model: pin levels and peripheral output levels
`timescale 1ns/1ps
module ppr_periph_model
    import ppr_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            step,
    output logic [NUM_PINS-1:0]  pin_in,
    output ppr_src_t             periph_src,
    output ppr_drv_t             periph_drv
);
    // =======
    // levels move only on request, so the bench can hold them steady
    // routed pins carry digital levels only; the model has no analog select
    initial {pin_in, periph_src, periph_drv} = '0;
    always @(posedge aclk)
    begin
        if (step)
        begin
            pin_in     <= NUM_PINS'($urandom);
            periph_src <= ppr_src_t'($urandom);
            periph_drv <= ppr_drv_t'($urandom);
        end
    end
endmodule : ppr_periph_model

/* bench/ppr_routing_tb_top.sv */
// self-checking bench of the pin routing block
`timescale 1ns/1ps
module ppr_routing_tb_top
    import ppr_pkg::*;
;
    // =======
    // signals, model state and counters
    logic aclk, aresetn = 1'h0, soft_rst_n = 1'h1, one_way_lock_option = 1'h0, step = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, routing_locked_bit;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n;
    logic [NUM_PINS-1:0] port_latch_output = '0, pin_direction_control = '0;
    logic [NUM_INPUTS-1:0] periph_in;
    logic [9:0] sv;
    logic oe;
    ppr_src_t periph_src;
    ppr_drv_t periph_drv;
    logic [4:0] in_m [NUM_INPUTS];
    logic [5:0] out_m [NUM_PINS];
    int bad_count = 0, compares = 0, cyc = 0;

    ppr_routing #(.LEADS(LEAD_COUNT), .LARGE_PINOUT(1'h0)) DUT (.aclk, .aresetn, .soft_rst_n,
        .one_way_lock_option, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .port_latch_output, .pin_direction_control,
        .periph_src, .periph_drv, .pin_out, .pin_oe_n, .periph_in, .routing_locked_bit);
    ppr_periph_model far_side (.aclk, .step, .pin_in, .periph_src, .periph_drv);

    // 250 MHz clock; timeout at cycle 20000, well above the roughly 750 cycles needed
    initial
    begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // =======
    // bus cycles and comparisons
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask : rd_reg
    // nothing else can interleave the three lock writes
    task automatic key(input logic [7:0] v);
        wr(LOCK_ADDR, KEY_FIRST);
        wr(LOCK_ADDR, KEY_SECOND);
        wr(LOCK_ADDR, v);
    endtask : key
    task automatic lk_chk(input logic [31:0] e);
        rd_reg(LOCK_ADDR);
        chk("lock reg", e, rd);
        chk("locked bit", e, 32'(routing_locked_bit));
    endtask : lk_chk
    task automatic sel_chk();
        foreach (in_m[i])
        begin
            rd_reg(IN_SEL_BASE + 12'(4 * i));
            chk("in_sel", {27'h0, in_m[i]}, rd);
        end
        foreach (out_m[p])
        begin
            rd_reg(OUT_SEL_BASE + 12'(4 * p));
            chk("out_sel", {26'h0, out_m[p]}, rd);
        end
    endtask : sel_chk
    // fresh levels, then two flops of latency before looking
    task automatic route_chk(input int p);
        step <= 1'h1;
        port_latch_output <= NUM_PINS'($urandom);
        pin_direction_control <= NUM_PINS'($urandom);
        @(posedge aclk);
        step <= 1'h0;
        repeat (3) @(posedge aclk);
        foreach (in_m[i]) chk("periph_in", 32'(pin_in[in_m[i]]), 32'(periph_in[i]));
        sv = {periph_src, port_latch_output[p]};
        chk("pin_out", 32'(out_m[p] < 6'hA ? sv[out_m[p]] : 1'h0), 32'(pin_out[p]));
        // serial clock and data may take the driver away from the direction bits
        oe = pin_direction_control[p];
        if (out_m[p] == 6'h7 && periph_drv.sck_own) oe = periph_drv.sck_oe_n;
        if (out_m[p] == 6'h8 && periph_drv.sdo_own) oe = periph_drv.sdo_oe_n;
        chk("pin_oe_n", 32'(oe), 32'(pin_oe_n[p]));
        rd_reg(PORT_ADDR);
        chk("port", {8'h0, pin_in}, rd);
    endtask : route_chk
    task automatic por();
        aresetn <= 1'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (in_m[i]) in_m[i] = IN_DEF_SMALL[i];
        foreach (out_m[p]) out_m[p] = OUT_SEL_RESET;
    endtask : por
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // =======
    // main sequence
    initial
    begin
        void'($urandom(99159));
        por();
        sel_chk();
        lk_chk(0);
        $display("test reset_defaults done");
        foreach (in_m[i])
        begin
            in_m[i] = (i == 1) ? in_m[0] : {2'($urandom_range(2)), 3'($urandom)};
            wr(IN_SEL_BASE + 12'(4 * i), {3'h0, in_m[i]});
        end
        in_m[7] = 5'h07;
        wr(IN_SEL_BASE + 12'h1C, 8'h07);
        wr(IN_SEL_BASE, 8'h1F);
        route_chk(0);
        $display("test input_routing done");
        for (int c = 0; c < 10; c++)
        begin
            out_m[c] = 6'(c);
            wr(OUT_SEL_BASE + 12'(4 * c), 8'(c));
            route_chk(c);
        end
        $display("test output_codes done");
        wr(LOCK_ADDR, 8'h01);
        lk_chk(0);
        key(8'h01);
        lk_chk(1);
        wr(OUT_SEL_BASE + 12'hC, 8'h00);
        sel_chk();
        wr(LOCK_ADDR, KEY_FIRST);
        wr(LOCK_ADDR, 8'h12);
        key(8'h00);
        lk_chk(0);
        wr(12'h300, 8'h00);
        chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
        rd_reg(12'h300);
        chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
        $display("test lock_keys done");
        one_way_lock_option <= 1'h1;
        key(8'h01);
        key(8'h00);
        lk_chk(1);
        soft_rst_n <= 1'h0;
        repeat (2) @(posedge aclk);
        soft_rst_n <= 1'h1;
        lk_chk(0);
        sel_chk();
        key(8'h01);
        por();
        lk_chk(0);
        sel_chk();
        $display("test resets done");
        tally_and_finish();
    end
endmodule : ppr_routing_tb_top

/* logic/ppr_pkg.sv */
// constants, types and register map of the peripheral pin routing block
package ppr_pkg;

    // ======================================================================
    // sizes
    localparam int NUM_INPUTS  = 13;
    localparam int NUM_PINS    = 24;
    localparam int ADDR_W      = 12;
    localparam int LEAD_COUNT  = 20;
    localparam int LEAD_WIDE   = 28;

    // ======================================================================
    // register map (byte addresses)
    localparam logic [11:0] IN_SEL_BASE  = 12'h000;
    localparam logic [11:0] OUT_SEL_BASE = 12'h100;
    localparam logic [11:0] LOCK_ADDR    = 12'h200;
    localparam logic [11:0] PORT_ADDR    = 12'h204;
    localparam logic [3:0]  PAGE_IN      = 4'h0;
    localparam logic [3:0]  PAGE_OUT     = 4'h1;

    // ======================================================================
    // field layout
    localparam int IN_PORT_LSB  = 3;
    localparam int IN_PIN_LSB   = 0;
    localparam int IN_SEL_W     = 5;
    localparam int OUT_SEL_W    = 6;
    localparam int LOCK_BIT     = 0;
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;

    // ======================================================================
    // lock keys, bus answers
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       LOCK_RESET  = 1'h0;
    localparam logic [5:0] OUT_SEL_RESET = 6'h00;

    // ======================================================================
    // output source codes
    localparam logic [5:0] SRC_LATCH  = 6'h00;
    localparam logic [5:0] SRC_CAP1   = 6'h01;
    localparam logic [5:0] SRC_CAP2   = 6'h02;
    localparam logic [5:0] SRC_PWM_UNIT_THREE   = 6'h03;
    localparam logic [5:0] SRC_PWM_UNIT_FOUR   = 6'h04;
    localparam logic [5:0] SRC_TXCK   = 6'h05;
    localparam logic [5:0] SRC_DT     = 6'h06;
    localparam logic [5:0] SRC_SCK    = 6'h07;
    localparam logic [5:0] SRC_SDO    = 6'h08;
    localparam logic [5:0] SRC_TIMER0_OUTPUT   = 6'h09;

    // input default pins, order: ext_int t0_clk t1_clk t1_gate t2_in cap1 cap2
    // ser_clk ser_dat ser_sel rx_dt tx_ck adc_trig (index 0 first)
    localparam logic [NUM_INPUTS-1:0][4:0] IN_DEF_SMALL = {
        5'h12, 5'h14, 5'h15, 5'h13, 5'h11, 5'h10,
        5'h13, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02, 5'h02};
    localparam logic [NUM_INPUTS-1:0][4:0] IN_DEF_LARGE = {
        5'h12, 5'h0F, 5'h0D, 5'h16, 5'h0E, 5'h0C,
        5'h13, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02, 5'h02};

    // peripheral output levels feeding the pin mux
    typedef struct packed {
        logic timer0_output;
        logic serial_data_out_line;
        logic serial_clock_line;
        logic sync_data;
        logic async_tx_sync_clock;
        logic pwm_unit_four;
        logic pwm_unit_three;
        logic capture_unit_two;
        logic capture_unit_one;
    } ppr_src_t;

    // driver ownership by peripherals that steer the pin driver themselves
    typedef struct packed {
        logic sck_own;
        logic sck_oe_n;
        logic sdo_own;
        logic sdo_oe_n;
    } ppr_drv_t;

    typedef enum logic [2:0] {RC_IN, RC_OUT, RC_LOCK, RC_PORT, RC_NONE} ppr_rclass_t;

endpackage : ppr_pkg

/* logic/ppr_routing.sv */
// peripheral pin routing matrix with axi4-lite register slave
`timescale 1ns/1ps
module ppr_routing
    import ppr_pkg::*;
#(
    parameter int   LEADS         = LEAD_COUNT,
    parameter logic LARGE_PINOUT  = 1'b0
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  soft_rst_n,
    input  wire logic                  one_way_lock_option,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    input  wire logic [NUM_PINS-1:0]   port_latch_output,
    input  wire logic [NUM_PINS-1:0]   pin_direction_control,
    input  wire ppr_src_t              periph_src,
    input  wire ppr_drv_t              periph_drv,
    output logic [NUM_PINS-1:0]        pin_out,
    output logic [NUM_PINS-1:0]        pin_oe_n,
    output logic [NUM_INPUTS-1:0]      periph_in,
    output logic                       routing_locked_bit
);

    // ======================================================================
    // helpers
    localparam logic [NUM_INPUTS-1:0][4:0] IN_DEF = LARGE_PINOUT ? IN_DEF_LARGE : IN_DEF_SMALL;

    typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_KEY2} ppr_key_t;

    // address decode, shared by write and read paths
    function automatic ppr_rclass_t reg_class(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        if (a[1:0] != 2'h0)                                       reg_class = RC_NONE;
        else if (a[11:8] == PAGE_IN && idx < 6'(NUM_INPUTS))      reg_class = RC_IN;
        else if (a[11:8] == PAGE_OUT && idx < 6'(NUM_PINS))       reg_class = RC_OUT;
        else if (a == LOCK_ADDR)                                  reg_class = RC_LOCK;
        else if (a == PORT_ADDR)                                  reg_class = RC_PORT;
        else                                                      reg_class = RC_NONE;
    endfunction : reg_class

    // pin level picked by an input selector; unused port code gives zero
    function automatic logic pin_pick(input logic [NUM_PINS-1:0] p, input logic [4:0] s);
        logic [4:0] n;
        n = {s[IN_PORT_LSB+:2], s[IN_PIN_LSB+:3]};
        pin_pick = (s[IN_PORT_LSB+:2] > PORT_C) ? 1'b0 : p[n];
    endfunction : pin_pick

    // pinouts of LEAD_WIDE leads or more only reach ports a and b; smaller ones reach a to c
    function automatic logic port_ok(input logic [1:0] port);
        port_ok = (LEADS >= LEAD_WIDE) ? (port <= PORT_B) : (port <= PORT_C);
    endfunction : port_ok

    // ======================================================================
    // state
    logic [NUM_INPUTS-1:0][4:0]  in_sel_ff,  nxt_in_sel;
    logic [NUM_PINS-1:0][5:0]    out_sel_ff, nxt_out_sel;
    logic                        locked_ff,  nxt_locked;
    ppr_key_t                    key_ff,     nxt_key;
    logic                        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic                        nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
    logic                        aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
    logic [ADDR_W-1:0]           aw_addr_ff, nxt_aw_addr;
    logic [7:0]                  w_data_ff,  nxt_w_data;
    logic                        w_lane_ff,  nxt_w_lane;
    logic [1:0]                  bresp_ff,   nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0]                 rdata_ff,   nxt_rdata;
    logic [NUM_PINS-1:0]         pin_out_ff, nxt_pin_out, pin_oe_n_ff, nxt_pin_oe_n;
    logic [NUM_INPUTS-1:0]       periph_in_ff, nxt_periph_in;
    logic                        do_wr;
    ppr_rclass_t                 wr_cls, rd_cls;

    assign do_wr  = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_cls = reg_class(aw_addr_ff);
    assign rd_cls = reg_class(s_axi_araddr);

    // ======================================================================
    // axi4-lite channel handshakes; one write and one read in flight
    always_comb
    begin
        nxt_aw_got  = aw_got_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_awready = awready_ff;
        nxt_w_got   = w_got_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_lane  = w_lane_ff;
        nxt_wready  = wready_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (s_axi_awvalid && awready_ff)
        begin
            nxt_aw_got  = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
            nxt_awready = 1'b0;
        end
        if (s_axi_wvalid && wready_ff)
        begin
            nxt_w_got  = 1'b1;
            nxt_w_data = s_axi_wdata[7:0];
            nxt_w_lane = s_axi_wstrb[0];
            nxt_wready = 1'b0;
        end
        if (do_wr)
        begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = (wr_cls == RC_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid  = 1'b0;
            nxt_aw_got  = 1'b0;
            nxt_w_got   = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready  = 1'b1;
        end
    end

    // read answer: port word shows pins directly, not the routing
    always_comb
    begin
        nxt_arready = arready_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (s_axi_arvalid && arready_ff)
        begin
            nxt_arready = 1'b0;
            nxt_rvalid  = 1'b1;
            nxt_rresp   = (rd_cls == RC_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (rd_cls)
                RC_IN:   nxt_rdata = {27'h0000000, in_sel_ff[s_axi_araddr[7:2]]};
                RC_OUT:  nxt_rdata = {26'h0000000, out_sel_ff[s_axi_araddr[7:2]]};
                RC_LOCK: nxt_rdata = {31'h00000000, locked_ff};
                RC_PORT: nxt_rdata = {8'h00, pin_in};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid  = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    // ======================================================================
    // selectors and lock; there is no sleep input, so sleep cannot disturb them
    always_comb
    begin
        nxt_in_sel  = in_sel_ff;
        nxt_out_sel = out_sel_ff;
        nxt_locked  = locked_ff;
        nxt_key     = key_ff;
        if (!soft_rst_n)
        begin
            nxt_locked = LOCK_RESET;
            nxt_key    = ST_IDLE;
        end
        else if (do_wr && w_lane_ff)
        begin
            // writes outside the lock register abort a pending key
            if (wr_cls != RC_LOCK)
                nxt_key = ST_IDLE;
            if (wr_cls == RC_IN && !locked_ff && port_ok(w_data_ff[IN_PORT_LSB+:2]))
                nxt_in_sel[aw_addr_ff[7:2]] = w_data_ff[IN_SEL_W-1:0];
            if (wr_cls == RC_OUT && !locked_ff)
                nxt_out_sel[aw_addr_ff[7:2]] = w_data_ff[OUT_SEL_W-1:0];
            if (wr_cls == RC_LOCK)
            begin
                case (key_ff)
                    ST_IDLE: nxt_key = (w_data_ff == KEY_FIRST)  ? ST_KEY1 : ST_IDLE;
                    ST_KEY1: nxt_key = (w_data_ff == KEY_SECOND) ? ST_KEY2 : ST_IDLE;
                    ST_KEY2:
                    begin
                        nxt_key = ST_IDLE;
                        // one-way: a set lock stays set until reset
                        if (!(one_way_lock_option && locked_ff))
                            nxt_locked = w_data_ff[LOCK_BIT];
                    end
                    default: nxt_key = ST_IDLE;
                endcase
            end
        end
    end

    // ======================================================================
    // pin side: input fan-in and per-pin output mux
    always_comb
    begin
        for (int i = 0; i < NUM_INPUTS; i++)
            nxt_periph_in[i] = pin_pick(pin_in, in_sel_ff[i]);
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++)
        begin : g_pin
            always_comb
            begin
                nxt_pin_oe_n[gp] = pin_direction_control[gp];
                case (out_sel_ff[gp])
                    SRC_LATCH: nxt_pin_out[gp] = port_latch_output[gp];
                    SRC_CAP1:  nxt_pin_out[gp] = periph_src.capture_unit_one;
                    SRC_CAP2:  nxt_pin_out[gp] = periph_src.capture_unit_two;
                    SRC_PWM_UNIT_THREE:  nxt_pin_out[gp] = periph_src.pwm_unit_three;
                    SRC_PWM_UNIT_FOUR:  nxt_pin_out[gp] = periph_src.pwm_unit_four;
                    SRC_TXCK:  nxt_pin_out[gp] = periph_src.async_tx_sync_clock;
                    SRC_DT:    nxt_pin_out[gp] = periph_src.sync_data;
                    SRC_SCK:
                    begin
                        nxt_pin_out[gp] = periph_src.serial_clock_line;
                        if (periph_drv.sck_own)
                            nxt_pin_oe_n[gp] = periph_drv.sck_oe_n;
                    end
                    SRC_SDO:
                    begin
                        nxt_pin_out[gp] = periph_src.serial_data_out_line;
                        if (periph_drv.sdo_own)
                            nxt_pin_oe_n[gp] = periph_drv.sdo_oe_n;
                    end
                    SRC_TIMER0_OUTPUT:  nxt_pin_out[gp] = periph_src.timer0_output;
                    default:   nxt_pin_out[gp] = 1'b0; // unassigned codes drive low
                endcase
            end
        end
    endgenerate

    // ======================================================================
    // registers; aresetn is the power-on / brown-out reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_sel_ff    <= IN_DEF;
            out_sel_ff   <= {NUM_PINS{OUT_SEL_RESET}};
            locked_ff    <= LOCK_RESET;
            key_ff       <= ST_IDLE;
            awready_ff   <= 1'b1;
            wready_ff    <= 1'b1;
            arready_ff   <= 1'b1;
            bvalid_ff    <= 1'b0;
            rvalid_ff    <= 1'b0;
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            aw_addr_ff   <= '0;
            w_data_ff    <= 8'h00;
            w_lane_ff    <= 1'b0;
            bresp_ff     <= RESP_OKAY;
            rresp_ff     <= RESP_OKAY;
            rdata_ff     <= 32'h00000000;
            pin_out_ff   <= '0;
            pin_oe_n_ff  <= '1;
            periph_in_ff <= '0;
        end
        else
        begin
            in_sel_ff    <= nxt_in_sel;
            out_sel_ff   <= nxt_out_sel;
            locked_ff    <= nxt_locked;
            key_ff       <= nxt_key;
            awready_ff   <= nxt_awready;
            wready_ff    <= nxt_wready;
            arready_ff   <= nxt_arready;
            bvalid_ff    <= nxt_bvalid;
            rvalid_ff    <= nxt_rvalid;
            aw_got_ff    <= nxt_aw_got;
            w_got_ff     <= nxt_w_got;
            aw_addr_ff   <= nxt_aw_addr;
            w_data_ff    <= nxt_w_data;
            w_lane_ff    <= nxt_w_lane;
            bresp_ff     <= nxt_bresp;
            rresp_ff     <= nxt_rresp;
            rdata_ff     <= nxt_rdata;
            pin_out_ff   <= nxt_pin_out;
            pin_oe_n_ff  <= nxt_pin_oe_n;
            periph_in_ff <= nxt_periph_in;
        end
    end

    assign s_axi_awready      = awready_ff;
    assign s_axi_wready       = wready_ff;
    assign s_axi_bvalid       = bvalid_ff;
    assign s_axi_bresp        = bresp_ff;
    assign s_axi_arready      = arready_ff;
    assign s_axi_rvalid       = rvalid_ff;
    assign s_axi_rdata        = rdata_ff;
    assign s_axi_rresp        = rresp_ff;
    assign pin_out            = pin_out_ff;
    assign pin_oe_n           = pin_oe_n_ff;
    assign periph_in          = periph_in_ff;
    assign routing_locked_bit = locked_ff;

    // ======================================================================
    // assertions
    a_lock_needs_key: assert property (@(posedge aclk) disable iff (!aresetn)
        (locked_ff != $past(locked_ff)) && $past(soft_rst_n) |-> $past(key_ff) == ST_KEY2)
        else $error("lock bit changed without key sequence");
    a_key_abort: assert property (@(posedge aclk) disable iff (!aresetn)
        key_ff == ST_KEY1 && do_wr && w_lane_ff && wr_cls == RC_LOCK
        && w_data_ff != KEY_SECOND && soft_rst_n |=> key_ff == ST_IDLE)
        else $error("wrong second key did not abort");
    a_one_way_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        one_way_lock_option && locked_ff && soft_rst_n |=> locked_ff)
        else $error("one-way lock was cleared");
    a_locked_sel_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        locked_ff |=> $stable(in_sel_ff) && $stable(out_sel_ff))
        else $error("selector changed while locked");
    a_soft_rst_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        !soft_rst_n |=> !locked_ff && $stable(in_sel_ff) && $stable(out_sel_ff))
        else $error("soft reset mishandled routing state");
    a_por_defaults: assert property (@(posedge aclk)
        $rose(aresetn) |-> in_sel_ff == IN_DEF && out_sel_ff == '0 && !locked_ff)
        else $error("power-on defaults wrong");
    a_input_route: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> periph_in_ff[1] == pin_pick($past(pin_in), $past(in_sel_ff[1])))
        else $error("input not routed from selected pin");
    a_latch_out: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && out_sel_ff[0] == SRC_LATCH |=> pin_out_ff[0] == $past(port_latch_output[0]))
        else $error("latch source not on pin");
    a_port_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && arready_ff && rd_cls == RC_PORT |=> rdata_ff[23:0] == $past(pin_in))
        else $error("port read not the pin level");
    c_lock_set: cover property (@(posedge aclk) disable iff (!aresetn) $rose(locked_ff));
    c_unlock: cover property (@(posedge aclk) disable iff (!aresetn) $fell(locked_ff));
    c_shared_pin: cover property (@(posedge aclk) disable iff (!aresetn)
        in_sel_ff[0] == in_sel_ff[1] && pin_in[in_sel_ff[0]]);
    c_locked_write: cover property (@(posedge aclk) disable iff (!aresetn)
        locked_ff && do_wr && wr_cls == RC_OUT);

endmodule : ppr_routing
